// ==== design/odd_classify.v ====
// raw orientation classifier from one acceleration sample
// assumes samples are stable while it is read, purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "odd_defs.vh"

module odd_classify (
   // sample
   input  wire signed [9:0] i_x,
   input  wire signed [9:0] i_y,
   input  wire signed [9:0] i_z,
   // present orientation
   input  wire        [1:0] i_code_now,
   // result
   output reg         [1:0] o_code,
   output reg               o_back,
   output reg               o_lock,
   output reg               o_overg
);

   function [15:0] mag;
      input signed [9:0] v;
      begin
         mag = v[9] ? {6'h00, -v} : {6'h00, v};
      end
   endfunction

   reg [15:0] ax;
   reg [15:0] ay;
   reg [15:0] az;
   reg [15:0] axy;
   reg        to_port;

   always @* begin
      ax = mag(i_x);
      ay = mag(i_y);
      az = mag(i_z);
      axy = (ax > ay) ? ax : ay;
      o_overg = (ax > {6'h00, `ODD_OVERG_LIM}) | (ay > {6'h00, `ODD_OVERG_LIM})
              | (az > {6'h00, `ODD_OVERG_LIM}); // RQ5
      o_lock = (axy * `ODD_RATIO_DEN) < (az * `ODD_ZL_NUM); // RQ7
      o_back = i_z[9]; // RQ9
      if (i_code_now[1]) begin
         to_port = (ay * `ODD_RATIO_DEN) > (ax * `ODD_LP_NUM); // RQ18
      end else begin
         to_port = !((ay * `ODD_RATIO_DEN) < (ax * `ODD_PL_NUM)); // RQ18
      end
      if (o_lock) begin
         o_code = i_code_now;
      end else if (to_port) begin
         o_code = i_y[9] ? `ODD_PORT_UP : `ODD_PORT_DN; // RQ8
      end else begin
         o_code = i_x[9] ? `ODD_LAND_L : `ODD_LAND_R; // RQ8
      end
   end

endmodule
`default_nettype wire

// ==== design/odd_debounce.v ====
// orientation debounce counter, advances once per time step
// assumes i_step is a one-cycle pulse from the same clock
`timescale 1ns/10ps
`default_nettype none
`include "odd_defs.vh"

module odd_debounce (
   // clock and reset
   input  wire       i_clock,
   input  wire       i_resetn,
   // control
   input  wire       i_restart,
   input  wire       i_step,
   input  wire       i_cond,
   input  wire       i_clear_mode,
   input  wire [7:0] i_limit,
   // result
   output wire       o_accept
);

   reg  [7:0] count;
   wire [8:0] count_inc;

   assign count_inc = {1'b0, count} + 9'h001;
   assign o_accept  = i_step & i_cond & (count_inc >= {1'b0, i_limit}); // RQ13

   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         count <= `ODD_COUNT_RST;
      end else if (i_restart || o_accept) begin
         count <= `ODD_COUNT_RST; // RQ14
      end else if (i_step) begin
         if (i_cond) begin
            count <= count_inc[7:0]; // RQ19
         end else if (i_clear_mode) begin
            count <= `ODD_COUNT_RST; // RQ12
         end else if (count != `ODD_COUNT_RST) begin
            count <= count - 8'h01; // RQ12
         end
      end
   end

endmodule
`default_nettype wire

// ==== design/odd_top.v ====
// orientation detect and debounce block with its three registers
// assumes register port, samples and mode inputs come from same-clock logic
//
// Contract
// (RQ1) change flag set on first result after activation
// (RQ2) change flag set when guard, side or code change
// (RQ3) status read clears change flag and interrupt
// (RQ4) status fields keep updating while flag set
// (RQ5) orientation held while any axis exceeds 1.25g
// (RQ6) flag at bit 7, resets 0, bits 5:3 zero
// (RQ7) bit 6 reads 1 when z-tilt lockout
// (RQ8) code: 00 up, 01 down, 10 right, 11 left
// (RQ9) bit 0: 0 front, 1 back
// (RQ10) side, code, guard start at zero
// (RQ11) config bit 6 enables detection, resets 0
// (RQ12) config bit 7: 0 decrements, 1 clears, reset 1
// (RQ13) latency equals count times sample period; here count time steps, at least one
// (RQ14) wake/sleep transition resets debounce counter
// (RQ15) time step follows sample rate and oversampling
// (RQ16) debounce count is eight bits, resets zero
// (RQ17) interrupt source bit follows flag and enable
// (RQ18) trip at 59 and 31 degrees around 45
// (RQ19) counter advances per sample, update at count; here it advances per time step
`timescale 1ns/10ps
`default_nettype none
`include "odd_defs.vh"

module odd_top #(
   parameter STEP_BASE_NS  = `ODD_STEP_BASE_NS,
   parameter STEP_BASE_CYC = STEP_BASE_NS / `ODD_CLK_PERIOD_NS
) (
   // clock and reset
   input  wire              i_clock,
   input  wire              i_resetn,
   // register port
   input  wire        [7:0] i_reg_addr,
   input  wire        [7:0] i_reg_wdata,
   input  wire              i_reg_wr,
   input  wire              i_reg_rd,
   output reg         [7:0] o_reg_rdata,
   // acceleration samples
   input  wire signed [9:0] i_accel_x,
   input  wire signed [9:0] i_accel_y,
   input  wire signed [9:0] i_accel_z,
   input  wire              i_sample_valid,
   // system mode
   input  wire              i_active,
   input  wire              i_sleep,
   input  wire        [2:0] i_output_sample_rate,
   input  wire        [1:0] i_oversample_mode,
   input  wire              i_orient_irq_enable,
   // status out
   output reg               o_orient_irq_source
);

   // base count cut to the counter width on purpose
   localparam integer BASE_LAST_INT = STEP_BASE_CYC - 1;
   localparam [15:0]  BASE_LAST     = BASE_LAST_INT[15:0];

   // time step multiplier per rate and oversampling mode
   function [7:0] step_mult;
      input [2:0] rate;
      input [1:0] osm;
      reg   [7:0] slow;
      begin
         slow = `ODD_MUL_16;
         case (osm)
            `ODD_OSM_LPLN: slow = `ODD_MUL_64;
            `ODD_OSM_LP:   slow = (rate >= 3'h6) ? `ODD_MUL_128 : `ODD_MUL_64;
            default:       slow = `ODD_MUL_16;
         endcase
         case (rate)
            3'h0:    step_mult = `ODD_MUL_1;
            3'h1:    step_mult = `ODD_MUL_2;
            3'h2:    step_mult = `ODD_MUL_4;
            3'h3:    step_mult = `ODD_MUL_8;
            3'h4:    step_mult = `ODD_MUL_16;
            default: step_mult = slow;
         endcase
         if (osm == `ODD_OSM_HIRES && rate != 3'h0) begin
            step_mult = `ODD_MUL_2;
         end
      end
   endfunction

   function is_addr;
      input [7:0] a;
      input [7:0] want;
      begin
         is_addr = (a == want);
      end
   endfunction

   // registers
   reg               orient_change_flag;
   reg               z_tilt_guard;
   reg         [1:0] orient_code;
   reg               back_front_bit;
   reg               orient_detect_enable;
   reg               debounce_clear_mode;
   reg         [7:0] orient_debounce_count;

   // internal state
   reg  signed [9:0] samp_x;
   reg  signed [9:0] samp_y;
   reg  signed [9:0] samp_z;
   reg               samp_seen;
   reg               active_q;
   reg               sleep_q;
   reg               first_pending;
   reg        [15:0] base_cnt;
   reg         [7:0] mult_cnt;
   reg               step;

   // next values
   reg               next_flag;
   reg         [7:0] next_rdata;

   wire        [1:0] raw_code;
   wire              raw_back;
   wire              raw_lock;
   wire              raw_overg;
   wire              running;
   wire              status_rd;
   wire              differs;
   wire              cond;
   wire              accept;
   wire              take_first;
   wire              restart;
   wire              update;
   wire        [7:0] mult_last;
   wire        [7:0] status_byte;

   // detection needs enable, active mode and a first sample
   assign running    = orient_detect_enable & i_active & samp_seen;
   assign status_rd  = i_reg_rd & is_addr(i_reg_addr, `ODD_ADDR_STATUS);
   assign differs    = (raw_code != orient_code) | (raw_back != back_front_bit)
                     | (raw_lock != z_tilt_guard);
   // over-range samples neither count nor update
   assign cond       = running & ~raw_overg & differs & ~first_pending; // RQ5
   assign take_first = running & ~raw_overg & first_pending & step;
   assign update     = accept | take_first;
   // counter restarts on a wake/sleep change or a stop
   assign restart    = (sleep_q != i_sleep) | ~running; // RQ14
   assign mult_last  = step_mult(i_output_sample_rate, i_oversample_mode) - 8'h01; // RQ15

   // unused status bits read as zero
   assign status_byte = {orient_change_flag, z_tilt_guard, `ODD_ST_ZERO,
                         orient_code, back_front_bit}; // RQ6

   odd_classify u_classify (
      .i_x        (samp_x),
      .i_y        (samp_y),
      .i_z        (samp_z),
      .i_code_now (orient_code),
      .o_code     (raw_code),
      .o_back     (raw_back),
      .o_lock     (raw_lock),
      .o_overg    (raw_overg)
   );

   odd_debounce u_debounce (
      .i_clock      (i_clock),
      .i_resetn     (i_resetn),
      .i_restart    (restart),
      .i_step       (step),
      .i_cond       (cond),
      .i_clear_mode (debounce_clear_mode),
      .i_limit      (orient_debounce_count),
      .o_accept     (accept)
   );

   // latest sample
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         samp_x    <= 10'h000;
         samp_y    <= 10'h000;
         samp_z    <= 10'h000;
         samp_seen <= 1'b0;
      end else if (i_sample_valid) begin
         samp_x    <= i_accel_x;
         samp_y    <= i_accel_y;
         samp_z    <= i_accel_z;
         samp_seen <= 1'b1;
      end
   end

   // time step generator
   // step is a one-clock pulse per debounce time step
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         base_cnt <= 16'h0000;
         mult_cnt <= 8'h00;
         step     <= 1'b0;
      end else if (!running) begin
         base_cnt <= 16'h0000;
         mult_cnt <= 8'h00;
         step     <= 1'b0;
      end else if (base_cnt >= BASE_LAST) begin
         base_cnt <= 16'h0000;
         if (mult_cnt >= mult_last) begin
            mult_cnt <= 8'h00;
            step     <= 1'b1; // RQ15
         end else begin
            mult_cnt <= mult_cnt + 8'h01;
            step     <= 1'b0;
         end
      end else begin
         base_cnt <= base_cnt + 16'h0001;
         step     <= 1'b0;
      end
   end

   // mode edge tracking
   // a rise of active re-arms the first result
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         active_q      <= 1'b0;
         sleep_q       <= 1'b0;
         first_pending <= 1'b1;
      end else begin
         active_q <= i_active;
         sleep_q  <= i_sleep;
         if (i_active && !active_q) begin
            first_pending <= 1'b1; // RQ1
         end else if (take_first) begin
            first_pending <= 1'b0;
         end
      end
   end

   // reported orientation, free to move while flag is set
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         orient_code    <= `ODD_PORT_UP; // RQ10
         back_front_bit <= 1'b0; // RQ10
         z_tilt_guard   <= 1'b0; // RQ10
      end else if (update) begin
         orient_code    <= raw_code; // RQ4 RQ19
         back_front_bit <= raw_back; // RQ9
         z_tilt_guard   <= raw_lock; // RQ7
      end
   end

   // change flag, set wins over read clear
   always @* begin
      next_flag = orient_change_flag;
      if (status_rd) begin
         next_flag = 1'b0; // RQ3
      end
      if (take_first) begin
         next_flag = 1'b1; // RQ1
      end
      if (accept) begin
         next_flag = 1'b1; // RQ2
      end
   end

   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         orient_change_flag  <= 1'b0; // RQ6
         o_orient_irq_source <= 1'b0;
      end else begin
         orient_change_flag  <= next_flag;
         o_orient_irq_source <= next_flag & i_orient_irq_enable; // RQ17 RQ3
      end
   end

   // configuration writes
   // status and unmapped writes fall through
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         debounce_clear_mode   <= `ODD_CFG_MODE_RST; // RQ12
         orient_detect_enable  <= `ODD_CFG_EN_RST; // RQ11
         orient_debounce_count <= `ODD_COUNT_RST; // RQ16
      end else if (i_reg_wr) begin
         if (is_addr(i_reg_addr, `ODD_ADDR_CFG)) begin
            debounce_clear_mode  <= i_reg_wdata[`ODD_CFG_MODE]; // RQ12
            orient_detect_enable <= i_reg_wdata[`ODD_CFG_EN]; // RQ11
         end
         if (is_addr(i_reg_addr, `ODD_ADDR_COUNT)) begin
            orient_debounce_count <= i_reg_wdata; // RQ16
         end
      end
   end

   // read data
   always @* begin
      case (i_reg_addr)
         `ODD_ADDR_STATUS: next_rdata = status_byte;
         `ODD_ADDR_CFG:    next_rdata = {debounce_clear_mode, orient_detect_enable, `ODD_CFG_ZERO};
         `ODD_ADDR_COUNT:  next_rdata = orient_debounce_count;
         default:          next_rdata = `ODD_BYTE_ZERO;
      endcase
   end

   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reg_rdata <= `ODD_BYTE_ZERO;
      end else if (i_reg_rd) begin
         o_reg_rdata <= next_rdata;
      end
   end

endmodule
`default_nettype wire

// ==== dv/odd_host.sv ====
// host processor model on the register port
// assumes strobes taken on the rising edge, read data valid after it
`timescale 1ns/10ps
`default_nettype none
module odd_host (
   input  wire logic       i_clock,
   input  wire logic [7:0] i_rdata,
   output var  logic [7:0] o_addr,
   output var  logic [7:0] o_wdata,
   output var  logic       o_wr,
   output var  logic       o_rd
);
   initial begin
      o_addr  = 8'h00;
      o_wdata = 8'h00;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clock);
      o_addr  = a;
      o_wdata = d;
      o_wr    = 1'b1;
      @(negedge i_clock);
      o_wr    = 1'b0;
      o_addr  = ~a;
      o_wdata = ~d;
   endtask
   // two reads back to back
   task rd(input logic [7:0] a, output logic [7:0] q1, output logic [7:0] q2);
      @(negedge i_clock);
      o_addr = a;
      o_rd   = 1'b1;
      @(negedge i_clock);
      q1 = i_rdata;
      @(negedge i_clock);
      q2     = i_rdata;
      o_rd   = 1'b0;
      o_addr = ~a;
   endtask
endmodule
`default_nettype wire

// ==== dv/odd_props.sv ====
// checker of the odd_top register port and interrupt source
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module odd_props #(
   parameter STEP_BASE_NS  = 1,
   parameter STEP_BASE_CYC = 1
) (
   input wire logic       i_clock,
   input wire logic       i_resetn,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       i_active,
   input wire logic       i_orient_irq_enable,
   input wire logic       o_orient_irq_source
);
   wire rd_st = i_reg_rd && i_reg_addr == 8'h10;
   wire wr_cf = i_reg_wr && i_reg_addr == 8'h11;
   wire wr_ct = i_reg_wr && i_reg_addr == 8'h12;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);
   property p_irq_off;
      !i_orient_irq_enable [*2] |-> !o_orient_irq_source;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq source while disabled");
   property p_st_zero;
      rd_st |=> o_reg_rdata[5:3] == 3'h0;
   endproperty
   a_st_zero: assert property (p_st_zero) else $error("status bits 5:3 not zero");
   property p_hold;
      !i_reg_rd |=> $stable(o_reg_rdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   property p_flag_irq;
      rd_st && i_orient_irq_enable && $past(i_orient_irq_enable) |=> o_reg_rdata[7] == $past(o_orient_irq_source);
   endproperty
   a_flag_irq: assert property (p_flag_irq) else $error("irq source differs from flag");
   property p_idle_clr;
      (!i_active) [*3] ##0 rd_st ##1 (rd_st && !i_active) |=> !o_reg_rdata[7];
   endproperty
   a_idle_clr: assert property (p_idle_clr) else $error("flag survived a status read");
   property p_ct_rw;
      wr_ct ##1 !i_reg_wr ##1 (i_reg_rd && i_reg_addr == 8'h12 && !i_reg_wr)
         |=> o_reg_rdata == $past(i_reg_wdata, 3);
   endproperty
   a_ct_rw: assert property (p_ct_rw) else $error("count readback wrong");
   property p_cf_rw;
      wr_cf ##1 !i_reg_wr ##1 (i_reg_rd && i_reg_addr == 8'h11 && !i_reg_wr)
         |=> o_reg_rdata == ($past(i_reg_wdata, 3) & 8'hC0);
   endproperty
   a_cf_rw: assert property (p_cf_rw) else $error("config readback wrong");
   property p_irq_rise;
      $rose(o_orient_irq_source) && $past(i_orient_irq_enable, 2) |-> $past(i_active) || $past(i_active, 2);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose while in standby");
endmodule
`default_nettype wire

// ==== dv/odd_tb_top.sv ====
// testbench of the orientation detect and debounce block
// assumes odd_top with a base time step of four clocks
`timescale 1ns/10ps
`default_nettype none
module odd_tb_top;
   localparam logic [29:0] P_DN = {10'h000, 10'h100, 10'h000};
   localparam logic [29:0] L_RT = {10'h100, 10'h000, 10'h000};
   logic              clock, resetn, sv, act, slp, en;
   logic signed [9:0] ax, ay, az;
   logic        [2:0] rate;
   logic        [1:0] osm;
   wire logic   [7:0] addr, wdata, rdata;
   wire logic         wr, rd, irq;
   logic        [7:0] q1, q2;
   int                n, lat, miscompares = 0, n_checks = 0;
   logic        [7:0] rst_exp [0:3] = '{8'h00, 8'h80, 8'h00, 8'h00};
   logic        [7:0] wr_exp [0:3] = '{8'h00, 8'hC0, 8'hFF, 8'h00};
   logic       [12:0] rt [0:3] = '{{3'h3, 2'h2, 8'h02}, {3'h3, 2'h0, 8'h08}, {3'h7, 2'h3, 8'h80},
                                   {3'h5, 2'h1, 8'h40}};
   logic       [37:0] rows [0:5] = '{
      {10'h000, 10'h300, 10'h000, 8'h80}, {10'h000, 10'h100, 10'h000, 8'h82},
      {10'h100, 10'h000, 10'h000, 8'h84}, {10'h300, 10'h000, 10'h000, 8'h86},
      {10'h300, 10'h000, 10'h39C, 8'h87}, {10'h00A, 10'h000, 10'h300, 8'hC7}};

   odd_top #(.STEP_BASE_CYC(4)) odd_top_inst (
      .i_clock              (clock),
      .i_resetn             (resetn),
      .i_reg_addr           (addr),
      .i_reg_wdata          (wdata),
      .i_reg_wr             (wr),
      .i_reg_rd             (rd),
      .o_reg_rdata          (rdata),
      .i_accel_x            (ax),
      .i_accel_y            (ay),
      .i_accel_z            (az),
      .i_sample_valid       (sv),
      .i_active             (act),
      .i_sleep              (slp),
      .i_output_sample_rate (rate),
      .i_oversample_mode    (osm),
      .i_orient_irq_enable  (en),
      .o_orient_irq_source  (irq)
   );
   odd_host odd_host_inst (
      .i_clock (clock),
      .i_rdata (rdata),
      .o_addr  (addr),
      .o_wdata (wdata),
      .o_wr    (wr),
      .o_rd    (rd)
   );

   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: read %h, want %h", $time, got, exp);
      end
   endtask
   task cmp_lat(input int got, input int min_n, input int max_n);
      n_checks++;
      if (got < min_n || got > max_n) begin
         miscompares++;
         $display("unexpected at %0t: latency %0d not in %0d..%0d", $time, got, min_n, max_n);
      end
   endtask
   task put(input logic [29:0] v);
      @(negedge clock);
      {ax, ay, az} = v;
      sv = 1'b1;
      @(negedge clock);
      sv = 1'b0;
   endtask
   task wait_irq;
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 2000) begin
         miscompares++;
         $display("unexpected at %0t: no interrupt in time", $time);
         report_and_stop;
      end
   endtask
   task clr;
      wait_irq;
      odd_host_inst.rd(8'h10, q1, q2);
   endtask
   // candidate, then a lapse or a sleep toggle, then candidate again
   task deb(input logic [7:0] c, input logic tog);
      odd_host_inst.wr(8'h11, c);
      put(L_RT);
      repeat (26) @(negedge clock);
      if (tog) begin
         slp = ~slp;
      end else begin
         put(P_DN);
      end
      repeat (6) @(negedge clock);
      put(L_RT);
      clr;
      lat = n;
      put(P_DN);
      clr;
   endtask

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      report_and_stop;
   end
   initial begin
      {ax, ay, az} = 30'h00000000;
      sv = 1'b0;
      act = 1'b0;
      slp = 1'b0;
      en = 1'b0;
      rate = 3'h0;
      osm = 2'h0;
      resetn = 1'b0;
      repeat (16) @(negedge clock);
      resetn = 1'b1;
      for (int i = 0; i < 4; i++) begin
         odd_host_inst.rd(8'h10 + i[7:0], q1, q2);
         cmp_byte(q1, rst_exp[i]);
         odd_host_inst.wr(8'h10 + i[7:0], 8'hFF);
         odd_host_inst.rd(8'h10 + i[7:0], q1, q2);
         cmp_byte(q1, wr_exp[i]);
      end
      odd_host_inst.wr(8'h12, 8'h00);
      en = 1'b1;
      act = 1'b1;
      for (int i = 0; i < 6; i++) begin
         put(rows[i][37:8]);
         clr;
         cmp_byte(q1, rows[i][7:0]);
         cmp_byte(q2, {1'b0, rows[i][6:0]});
         cmp_byte({7'h00, irq}, 8'h00);
      end
      en = 1'b0;
      put({10'h190, 10'h000, 10'h000});
      repeat (40) @(negedge clock);
      odd_host_inst.rd(8'h10, q1, q2);
      cmp_byte(q1, 8'h47);
      put({10'h000, 10'h300, 10'h000});
      repeat (20) @(negedge clock);
      put(P_DN);
      repeat (20) @(negedge clock);
      cmp_byte({7'h00, irq}, 8'h00);
      odd_host_inst.rd(8'h10, q1, q2);
      cmp_byte(q1, 8'h82);
      en = 1'b1;
      odd_host_inst.wr(8'h12, 8'h08);
      deb(8'hC0, 1'b0);
      cmp_lat(lat, 25, 80);
      deb(8'h40, 1'b0);
      cmp_lat(lat, 0, 22);
      deb(8'h40, 1'b1);
      cmp_lat(lat, 18, 80);
      odd_host_inst.wr(8'h12, 8'h02);
      odd_host_inst.wr(8'h11, 8'hC0);
      for (int i = 0; i < 4; i++) begin
         rate = rt[i][12:10];
         osm = rt[i][9:8];
         put(i[0] ? P_DN : L_RT);
         clr;
         cmp_lat(n, 4 * rt[i][7:0] - 2, 8 * rt[i][7:0] + 4);
      end
      rate = 3'h0;
      osm = 2'h0;
      act = 1'b0;
      repeat (4) @(negedge clock);
      odd_host_inst.rd(8'h10, q1, q2);
      cmp_byte(q2, 8'h02);
      act = 1'b1;
      clr;
      cmp_lat(n, 0, 12);
      cmp_byte(q1, 8'h82);
      report_and_stop;
   end
endmodule

bind odd_top odd_props #(
   .STEP_BASE_NS  (STEP_BASE_NS),
   .STEP_BASE_CYC (STEP_BASE_CYC)
) odd_props_inst (
   .i_clock             (i_clock),
   .i_resetn            (i_resetn),
   .i_reg_addr          (i_reg_addr),
   .i_reg_wdata         (i_reg_wdata),
   .i_reg_wr            (i_reg_wr),
   .i_reg_rd            (i_reg_rd),
   .o_reg_rdata         (o_reg_rdata),
   .i_active            (i_active),
   .i_orient_irq_enable (i_orient_irq_enable),
   .o_orient_irq_source (o_orient_irq_source)
);
`default_nettype wire

// ==== inc/odd_defs.vh ====
// constants of the orientation detect and debounce block
// assumes 20 MHz clock and 10-bit signed samples at 2g full scale
`ifndef ODD_DEFS_VH
`define ODD_DEFS_VH

// register map
`define ODD_ADDR_STATUS    8'h10
`define ODD_ADDR_CFG       8'h11
`define ODD_ADDR_COUNT     8'h12

// status fields
`define ODD_ST_CHG         7
`define ODD_ST_ZTILT       6
`define ODD_ST_CODE_HI     2
`define ODD_ST_CODE_LO     1
`define ODD_ST_BF          0
`define ODD_ST_ZERO        3'h0

// config fields and reset values
`define ODD_CFG_MODE       7
`define ODD_CFG_EN         6
`define ODD_CFG_MODE_RST   1'b1
`define ODD_CFG_EN_RST     1'b0
`define ODD_CFG_ZERO       6'h00
`define ODD_COUNT_RST      8'h00
`define ODD_BYTE_ZERO      8'h00

// orientation codes
`define ODD_PORT_UP        2'b00
`define ODD_PORT_DN        2'b01
`define ODD_LAND_R         2'b10
`define ODD_LAND_L         2'b11

// magnitude limits, 256 counts per g
`define ODD_OVERG_LIM      10'h140
`define ODD_RATIO_DEN      16'h0020
`define ODD_LP_NUM         16'h0035
`define ODD_PL_NUM         16'h0013
`define ODD_ZL_NUM         16'h0012

// timing
`define ODD_CLK_PERIOD_NS  50
`define ODD_STEP_BASE_NS   1250000

// time step multipliers over the 1.25 ms base step
`define ODD_MUL_1          8'h01
`define ODD_MUL_2          8'h02
`define ODD_MUL_4          8'h04
`define ODD_MUL_8          8'h08
`define ODD_MUL_16         8'h10
`define ODD_MUL_64         8'h40
`define ODD_MUL_128        8'h80

// oversampling modes
`define ODD_OSM_NORMAL     2'b00
`define ODD_OSM_LPLN       2'b01
`define ODD_OSM_HIRES      2'b10
`define ODD_OSM_LP         2'b11

`endif
